// [lvd_pkg.sv]
package lvd_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_MASK = 4'h8;
    localparam logic [3:0] OFS_GLOB = 4'hC;
    // ----------------------------------------
    // control fields
    // ----------------------------------------
    localparam int BIT_STABLE = 5;
    localparam int BIT_EN = 4;
    localparam int LVL_LSB = 0;
    localparam int LVL_W = 4;
    localparam logic [3:0] LVL_RESET = 4'h5;
    localparam logic [3:0] LVL_EXT = 4'hF;
    localparam logic [3:0] LVL_MIN = 4'h2;
    localparam int CTRL_W = 6;
    // ----------------------------------------
    // status, mask and global fields
    // ----------------------------------------
    localparam int IRQ_LOW = 0;
    localparam int IRQ_STABLE = 1;
    localparam int IRQ_W = 2;
    localparam int GLB_GIE = 0;
    localparam int STRB_LANE = 0;
    // ----------------------------------------
    // bus answers and timing
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CLK_NS = 100;
    localparam int REF_STARTUP_NS = 20000;
    localparam int SETTLE_NS = 1000;
    localparam int CNT_W = 16;
    // ----------------------------------------
    // detector states
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_WAIT = 2'b01,
        ST_READY = 2'b10
    } lvd_state_t;
endpackage : lvd_pkg

// [lvd_ctrl.sv]
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - control bits 7 and 6 always read as zero
// - stable flag at bit 5 reads one only when detection is valid
// - enable at bit 4 powers comparator and divider up or down
// - level code all ones routes comparator to external input
// - codes 2 to 14 pick rising divider taps, 0 and 1 reserved
// - each enable waits a settle interval before flags are trusted
// - early false flag setting tolerated and clearable by software
// - low flag cannot be raised before reference is stable
// - start-up interval timed in real time, not clock dependent
// - reference off with brown-out off needs full start-up time
// - detector keeps running in sleep and sets the flag there
// - flag set in sleep wakes device, vector only if global on
// - any reset returns control to reset state, detector off
// - flag set when selected tap falls below the reference
// - flag set with interrupt enabled branches to the vector
module lvd_ctrl
    import lvd_pkg::*;
#(
    parameter int ADDR_W = 4,
    parameter int CLK_PERIOD_NS = CLK_NS,
    parameter int REF_NS = REF_STARTUP_NS,
    parameter int SET_NS = SETTLE_NS
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // analog side
    input wire logic cmp_low_async,
    input wire logic brownout_reset_en,
    output logic detector_power_enable,
    output logic [LVL_W-1:0] tap_select,
    output logic external_trip_input_sel,
    // cpu side
    input wire logic sleep_active,
    output logic irq,
    output logic irq_vector_req,
    output logic wake_req
);
    // ----------------------------------------
    // timing counts
    // ----------------------------------------
    localparam int REF_I = (REF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SET_I = (SET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] REF_CYC = CNT_W'(REF_I < 1 ? 1 : REF_I);
    localparam logic [CNT_W-1:0] SET_CYC = CNT_W'(SET_I < 1 ? 1 : SET_I);
    localparam int REF_MIN = 8;

    if (ADDR_W < 4 || REF_I < REF_MIN || REF_I >= 2**CNT_W ||
        SET_I >= 2**CNT_W) begin : g_chk
        $error("lvd_ctrl: parameter out of range");
    end

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic addr_ok(input logic [3:0] a);
        addr_ok = (a == OFS_CTRL) || (a == OFS_STAT) ||
                  (a == OFS_MASK) || (a == OFS_GLOB);
    endfunction : addr_ok

    function automatic logic lvl_reserved(input logic [3:0] l);
        lvl_reserved = (l < LVL_MIN);
    endfunction : lvl_reserved

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_have_q, w_have_q;
    logic [3:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wlane_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic en_q;
    logic [LVL_W-1:0] lvl_q, tap_q;
    logic ext_q;
    logic [IRQ_W-1:0] stat_q, mask_q;
    logic gie_q;
    logic irq_q, vec_q, wake_q;
    logic cmp_m_q, cmp_s_q;
    logic [CNT_W-1:0] cnt_q;
    lvd_state_t st_q;
    logic do_wr, wr_ctrl, wr_stat, wr_mask, wr_glob;
    logic [IRQ_W-1:0] stat_set, stat_clr;
    logic [31:0] rd_mux;

    assign do_wr = aw_have_q && w_have_q && !bvalid_q;
    assign wr_ctrl = do_wr && wlane_q && (awaddr_q == OFS_CTRL);
    assign wr_stat = do_wr && wlane_q && (awaddr_q == OFS_STAT);
    assign wr_mask = do_wr && wlane_q && (awaddr_q == OFS_MASK);
    assign wr_glob = do_wr && wlane_q && (awaddr_q == OFS_GLOB);

    // ----------------------------------------
    // write channels
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            aw_have_q <= 1'b0;
            awaddr_q <= 4'h0;
        end else if (awvalid && awready_q) begin
            awready_q <= 1'b0;
            aw_have_q <= 1'b1;
            awaddr_q <= awaddr[3:0];
        end else begin
            if (do_wr) begin
                aw_have_q <= 1'b0;
            end
            awready_q <= !aw_have_q && !bvalid_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b0;
            w_have_q <= 1'b0;
            wdata_q <= 8'h00;
            wlane_q <= 1'b0;
        end else if (wvalid && wready_q) begin
            wready_q <= 1'b0;
            w_have_q <= 1'b1;
            wdata_q <= wdata[7:0];
            wlane_q <= wstrb[STRB_LANE];
        end else begin
            if (do_wr) begin
                w_have_q <= 1'b0;
            end
            wready_q <= !w_have_q && !bvalid_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q <= addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (araddr[3:0])
            OFS_CTRL: begin
                rd_mux[BIT_STABLE] = (st_q == ST_READY);
                rd_mux[BIT_EN] = en_q;
                rd_mux[LVL_W-1:0] = lvl_q;
            end
            OFS_STAT: rd_mux[IRQ_W-1:0] = stat_q;
            OFS_MASK: rd_mux[IRQ_W-1:0] = mask_q;
            OFS_GLOB: rd_mux[GLB_GIE] = gie_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= addr_ok(araddr[3:0]) ? RESP_OKAY : RESP_SLVERR;
        end else begin
            if (rvalid_q && rready) begin
                rvalid_q <= 1'b0;
            end
            arready_q <= !rvalid_q;
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    // reset state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_q <= 1'b0;
            lvl_q <= LVL_RESET;
        end else if (wr_ctrl) begin
            en_q <= wdata_q[BIT_EN];
            lvl_q <= wdata_q[LVL_LSB +: LVL_W];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tap_q <= LVL_MIN;
            ext_q <= 1'b0;
        end else begin
            ext_q <= (lvl_q == LVL_EXT);
            tap_q <= lvl_reserved(lvl_q) ? LVL_MIN : lvl_q;
        end
    end

    // ----------------------------------------
    // comparator synchroniser
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_m_q <= 1'b0;
            cmp_s_q <= 1'b0;
        end else begin
            cmp_m_q <= cmp_low_async;
            cmp_s_q <= cmp_m_q;
        end
    end

    // ----------------------------------------
    // stabilisation sequencer
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_OFF;
            cnt_q <= '0;
        end else begin
            case (st_q)
                ST_OFF: begin
                    if (en_q) begin
                        st_q <= ST_WAIT;
                        cnt_q <= brownout_reset_en ? SET_CYC : REF_CYC;
                    end
                end
                ST_WAIT: begin
                    if (!en_q) begin
                        st_q <= ST_OFF;
                    end else if (cnt_q == '0) begin
                        st_q <= ST_READY;
                    end else begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end
                end
                ST_READY: begin
                    if (!en_q) begin
                        st_q <= ST_OFF;
                    end
                end
                default: st_q <= ST_OFF;
            endcase
        end
    end

    // ----------------------------------------
    // interrupt status
    // ----------------------------------------
    always_comb begin
        stat_set = '0;
        stat_set[IRQ_LOW] = cmp_s_q && en_q && (st_q == ST_READY);
        stat_set[IRQ_STABLE] = (st_q == ST_WAIT) && en_q &&
                               (cnt_q == '0);
        stat_clr = wr_stat ? wdata_q[IRQ_W-1:0] : '0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= '0;
            gie_q <= 1'b0;
        end else begin
            if (wr_mask) begin
                mask_q <= wdata_q[IRQ_W-1:0];
            end
            if (wr_glob) begin
                gie_q <= wdata_q[GLB_GIE];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
            vec_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & mask_q);
            vec_q <= (|(stat_q & mask_q)) && gie_q;
            wake_q <= sleep_active && stat_q[IRQ_LOW];
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign detector_power_enable = en_q;
    assign tap_select = tap_q;
    assign external_trip_input_sel = ext_q;
    assign irq = irq_q;
    assign irq_vector_req = vec_q;
    assign wake_req = wake_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_cold_start;
        $rose(en_q) && !brownout_reset_en && (st_q == ST_OFF);
    endsequence

    property p_hi_zero;
        rvalid_q |-> rdata_q[31:CTRL_W] == '0;
    endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("upper read bits not zero");

    property p_stable_en;
        (st_q == ST_READY) |-> en_q || $fell(en_q);
    endproperty
    a_stable_en: assert property (p_stable_en)
        else $error("stable without enable");

    property p_pwr_off;
        !en_q && $past(!en_q) |-> st_q == ST_OFF;
    endproperty
    a_pwr_off: assert property (p_pwr_off)
        else $error("sequencer running while disabled");

    property p_ext;
        lvl_q == LVL_EXT |=> ext_q;
    endproperty
    a_ext: assert property (p_ext)
        else $error("external input not selected");

    property p_tap;
        !lvl_reserved(lvl_q) && lvl_q != LVL_EXT |=>
            tap_q == $past(lvl_q) && !ext_q;
    endproperty
    a_tap: assert property (p_tap)
        else $error("divider tap mismatch");

    property p_settle;
        s_cold_start |=> (st_q != ST_READY) [*8];
    endproperty
    a_settle: assert property (p_settle)
        else $error("ready before start-up");

    property p_ref_load;
        (st_q == ST_OFF) && en_q && !brownout_reset_en |=>
            cnt_q == REF_CYC;
    endproperty
    a_ref_load: assert property (p_ref_load)
        else $error("full start-up count not loaded");

    property p_gate;
        $rose(stat_q[IRQ_LOW]) |-> $past(st_q == ST_READY);
    endproperty
    a_gate: assert property (p_gate)
        else $error("low flag raised before stable");

    property p_detect;
        (st_q == ST_READY) && en_q && cmp_s_q |=> stat_q[IRQ_LOW];
    endproperty
    a_detect: assert property (p_detect)
        else $error("low supply not flagged");

    property p_wake;
        sleep_active && stat_q[IRQ_LOW] |=> wake_q;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake from sleep");

    property p_vector;
        stat_q[IRQ_LOW] && mask_q[IRQ_LOW] && gie_q |=> vec_q;
    endproperty
    a_vector: assert property (p_vector)
        else $error("no vector request");

    property p_sticky;
        stat_q[IRQ_LOW] && !stat_clr[IRQ_LOW] |=> stat_q[IRQ_LOW];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("low flag dropped without clear");
endmodule : lvd_ctrl

// [lvd_cmp_model.sv]
`timescale 1ns/1ps
module lvd_cmp_model
    import lvd_pkg::*;
#(
    parameter int TRIP_BASE_MV = 1000,
    parameter int TRIP_STEP_MV = 200
) (
    // clock
    input wire logic aclk,
    // control from the block
    input wire logic detector_power_enable,
    input wire logic [LVL_W-1:0] tap_select,
    input wire logic external_trip_input_sel,
    // supply and pin levels
    input wire logic [15:0] supply_mv,
    input wire logic ext_pin_low,
    // comparator output
    output logic cmp_low_async
);
    // ----------------------------------------
    // comparator
    // ----------------------------------------
    logic idle_q = 1'b0;
    logic low_now;
    always @(posedge aclk) begin
        idle_q <= ~idle_q;
    end
    always_comb begin
        if (external_trip_input_sel) begin
            low_now = ext_pin_low;
        end else begin
            low_now = int'(supply_mv) <
                TRIP_BASE_MV + TRIP_STEP_MV * int'(tap_select);
        end
    end
    always_comb begin
        cmp_low_async = detector_power_enable ? low_now : idle_q;
    end
endmodule : lvd_cmp_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import lvd_pkg::*;
    localparam int REF_NS_TB = 2000;
    localparam int REF_CYC = REF_NS_TB / CLK_NS;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr, araddr, wstrb, tap_select;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic cmp_low_async, brownout_reset_en, detector_power_enable;
    logic external_trip_input_sel, sleep_active, irq, irq_vector_req;
    logic wake_req, ext_pin_low;
    logic [15:0] supply_mv;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;

    lvd_ctrl #(.REF_NS(REF_NS_TB), .SET_NS(300)) lvd_ctrl_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cmp_low_async(cmp_low_async),
        .brownout_reset_en(brownout_reset_en),
        .detector_power_enable(detector_power_enable),
        .tap_select(tap_select),
        .external_trip_input_sel(external_trip_input_sel),
        .sleep_active(sleep_active), .irq(irq),
        .irq_vector_req(irq_vector_req), .wake_req(wake_req)
    );
    lvd_cmp_model lvd_cmp_model_i (
        .aclk(aclk), .detector_power_enable(detector_power_enable),
        .tap_select(tap_select),
        .external_trip_input_sel(external_trip_input_sel),
        .supply_mv(supply_mv), .ext_pin_low(ext_pin_low),
        .cmp_low_async(cmp_low_async)
    );

    initial begin
        aclk = 1'b0;
        forever #(CLK_NS / 2) aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    task automatic timed_out(input string what);
        num_errors++;
        $display("CHECK FAILED %s expected answer seen timeout", what);
        final_report();
    endtask : timed_out

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] resp);
        logic done;
        done = 1'b0;
        resp = 2'h3;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100 && !done; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                done = 1'b1;
            end
        end
        bready <= 1'b0;
        @(posedge aclk);
        if (!done) timed_out("write");
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
        logic done;
        done = 1'b0;
        d = '0;
        resp = 2'h3;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100 && !done; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                resp = rresp;
                done = 1'b1;
            end
        end
        rready <= 1'b0;
        @(posedge aclk);
        if (!done) timed_out("read");
    endtask : axi_rd

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, 4'hf, r);
        repeat (2) @(posedge aclk);
    endtask : wr

    task automatic rd_chk(input string what, input logic [3:0] a,
                          input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        check(what, d, exp);
    endtask : rd_chk

    task automatic wait_stable();
        logic [31:0] d;
        logic [1:0] r;
        d = '0;
        for (int n = 0; n < 40 && d[BIT_STABLE] !== 1'b1; n++) begin
            axi_rd(OFS_CTRL, d, r);
        end
        if (d[BIT_STABLE] !== 1'b1) timed_out("stable");
    endtask : wait_stable

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int t0;
        aresetn = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {brownout_reset_en, sleep_active, ext_pin_low} = '0;
        supply_mv = 16'h0bb8;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk("ctrl reset", OFS_CTRL, 32'h0000_0005);
        rd_chk("stat reset", OFS_STAT, 32'h0000_0000);
        rd_chk("mask reset", OFS_MASK, 32'h0000_0000);
        check("power reset", 32'(detector_power_enable), 32'h0);
        $display("test reset done");
        for (int c = 0; c < 16; c++) begin
            wr(OFS_CTRL, 32'h0000_00e0 | 32'(c));
            rd_chk("ctrl level", OFS_CTRL, 32'(c));
            check("ext sel", 32'(external_trip_input_sel), 32'(c == 15));
            if (c < 15) check("tap", 32'(tap_select), 32'(c < 2 ? 2 : c));
        end
        rd_chk("no flag when off", OFS_STAT, 32'h0000_0000);
        $display("test levels done");
        supply_mv <= 16'h07d0;
        t0 = cyc;
        wr(OFS_CTRL, 32'h0000_0018);
        rd_chk("ctrl waiting", OFS_CTRL, 32'h0000_0018);
        rd_chk("flag gated", OFS_STAT, 32'h0000_0000);
        check("power on", 32'(detector_power_enable), 32'h1);
        wait_stable();
        check("ref wait", 32'(cyc - t0 >= REF_CYC), 32'h1);
        rd_chk("ctrl stable", OFS_CTRL, 32'h0000_0038);
        wait_cyc(6);
        rd_chk("low flag", OFS_STAT, 32'h0000_0003);
        $display("test bring-up done");
        wr(OFS_STAT, 32'h0000_0001);
        rd_chk("set wins", OFS_STAT, 32'h0000_0003);
        wr(OFS_MASK, 32'h0000_0001);
        check("irq", 32'(irq), 32'h1);
        check("vector gated", 32'(irq_vector_req), 32'h0);
        wr(OFS_GLOB, 32'h0000_0001);
        check("vector", 32'(irq_vector_req), 32'h1);
        supply_mv <= 16'h0bb8;
        wait_cyc(6);
        rd_chk("sticky", OFS_STAT, 32'h0000_0003);
        axi_wr(OFS_STAT, 32'h0000_0003, 4'h0, r);
        rd_chk("strobe off", OFS_STAT, 32'h0000_0003);
        wr(OFS_STAT, 32'h0000_0001);
        rd_chk("cleared", OFS_STAT, 32'h0000_0002);
        check("irq off", 32'(irq), 32'h0);
        $display("test irq done");
        wr(OFS_GLOB, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0000);
        rd_chk("stable drop", OFS_CTRL, 32'h0000_0000);
        check("power off", 32'(detector_power_enable), 32'h0);
        brownout_reset_en <= 1'b1;
        wr(OFS_CTRL, 32'h0000_001f);
        t0 = cyc;
        wait_stable();
        check("short wait", 32'(cyc - t0 < REF_CYC), 32'h1);
        wr(OFS_STAT, 32'h0000_0003);
        sleep_active <= 1'b1;
        ext_pin_low <= 1'b1;
        wait_cyc(6);
        check("wake", 32'(wake_req), 32'h1);
        check("no vector", 32'(irq_vector_req), 32'h0);
        rd_chk("sleep flag", OFS_STAT, 32'h0000_0001);
        wr(OFS_GLOB, 32'h0000_0001);
        check("sleep vector", 32'(irq_vector_req), 32'h1);
        $display("test sleep done");
        axi_rd(4'h2, d, r);
        check("unaligned resp", 32'(r), 32'(RESP_SLVERR));
        check("unaligned data", d, 32'h0000_0000);
        axi_wr(4'h3, 32'h0000_0001, 4'hf, r);
        check("bad write resp", 32'(r), 32'(RESP_SLVERR));
        $display("test bus errors done");
        sleep_active <= 1'b0;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk("ctrl after reset", OFS_CTRL, 32'h0000_0005);
        check("power after reset", 32'(detector_power_enable), 32'h0);
        $display("test mid reset done");
        final_report();
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : wait_cyc
endmodule : tb_top
